// ---- include/ebs_pkg.sv ----
// constants and types for the external bus cycle sequencer
package ebs_pkg;
  // register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDATA_OFS = 8'h08;
  localparam logic [7:0] CMD_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] RDATA_OFS = 8'h14;
  // chip_select_timing_config fields
  localparam int F_AS = 0;
  localparam int F_ASX = 1;
  localparam int F_CMD = 3;
  localparam int F_WS = 5;
  localparam int F_ACC = 6;
  localparam int F_HLD = 11;
  localparam int F_REN = 13;
  localparam int F_RPOL = 14;
  localparam int F_RASY = 15;
  localparam int CFG_W = 16;
  // command and status bits
  localparam int C_GO = 0;
  localparam int C_WR = 1;
  localparam int C_BHE = 2;
  localparam int S_BUSY = 0;
  localparam int S_GRANT = 1;
  localparam int S_BUS_REGAIN_REQUEST_N = 2;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [5:0] CNT_ONE = 6'h01;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_AS = 4'h1,
    ST_CMD = 4'h2,
    ST_WSET = 4'h3,
    ST_ACC = 4'h4,
    ST_RDYW = 4'h5,
    ST_HOLDP = 4'h6,
    ST_REL = 4'h7,
    ST_HELD = 4'h8,
    ST_REG = 4'h9
  } ebs_state_t;
endpackage

// ---- rtl/ebs_top.sv ----
// external bus cycle sequencer with axi4-lite register slave
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module ebs_top #(
  parameter int AW = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic link_clock,
  input wire logic ready_in,
  input wire logic hold_n,
  input wire logic [15:0] read_data_in,
  output logic [23:0] address_out,
  output logic address_oe,
  output logic [15:0] write_data_out,
  output logic write_data_oe,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic address_latch_enable,
  output logic byte_high_enable_n,
  output logic control_oe,
  output logic bus_hold_grant_n,
  output logic bus_regain_request_n
);
  function automatic logic [31:0] ebs_merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic ebs_active(input logic lvl, input logic pol);
    return lvl == pol;
  endfunction

  function automatic logic [5:0] ebs_len(input ebs_pkg::ebs_state_t s,
      input logic [ebs_pkg::CFG_W-1:0] c, input logic wchg);
    logic [5:0] n;
    n = ebs_pkg::CNT_ZERO;
    case (s)
      ebs_pkg::ST_AS: begin
        n = ebs_pkg::CNT_ONE + {5'h00, c[ebs_pkg::F_AS]};
        if (wchg) begin
          n = n + {4'h0, c[ebs_pkg::F_ASX +: 2]};
        end
      end
      ebs_pkg::ST_CMD: n = {4'h0, c[ebs_pkg::F_CMD +: 2]};
      ebs_pkg::ST_WSET: n = {5'h00, c[ebs_pkg::F_WS]};
      ebs_pkg::ST_ACC: n = {1'b0, c[ebs_pkg::F_ACC +: 5]} + ebs_pkg::CNT_ONE;
      ebs_pkg::ST_HOLDP: n = {4'h0, c[ebs_pkg::F_HLD +: 2]};
      default: n = ebs_pkg::CNT_ZERO;
    endcase
    return n;
  endfunction

  // next phase of the five, skipping phases programmed to zero
  function automatic ebs_pkg::ebs_state_t ebs_after(
      input ebs_pkg::ebs_state_t s, input logic [ebs_pkg::CFG_W-1:0] c);
    ebs_pkg::ebs_state_t t;
    t = s;
    for (int i = 0; i < 3; i++) begin
      case (t)
        ebs_pkg::ST_AS: t = ebs_pkg::ST_CMD;
        ebs_pkg::ST_CMD: t = ebs_pkg::ST_WSET;
        ebs_pkg::ST_WSET: t = ebs_pkg::ST_ACC;
        ebs_pkg::ST_ACC: t = ebs_pkg::ST_HOLDP;
        ebs_pkg::ST_RDYW: t = ebs_pkg::ST_HOLDP;
        ebs_pkg::ST_HOLDP: t = ebs_pkg::ST_IDLE;
        default: t = t;
      endcase
      if (t == ebs_pkg::ST_ACC || t == ebs_pkg::ST_IDLE ||
          ebs_len(t, c, 1'b0) != ebs_pkg::CNT_ZERO) begin
        break;
      end
    end
    return t;
  endfunction

  // ---------------- system clock domain ----------------
  logic [31:0] cfg_reg;
  logic [23:0] addr_reg;
  logic [15:0] wdata_reg;
  logic wr_reg;
  logic bhe_reg;
  logic busy_reg;
  logic req_tgl_reg;
  logic [31:0] rd_reg;
  logic done_s1, done_s2, done_s3;
  logic grant_s1, grant_s2;
  logic bus_regain_request_n_s1, bus_regain_request_n_s2;
  logic [AW-1:0] aw_addr_reg;
  logic aw_have, w_have;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic done_tgl_reg;
  logic [15:0] link_rd_reg;
  logic done_evt;
  logic do_write;

  assign done_evt = done_s2 ^ done_s3;
  assign do_write = aw_have && w_have && !bvalid;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      grant_s1 <= 1'b0;
      grant_s2 <= 1'b0;
      bus_regain_request_n_s1 <= 1'b0;
      bus_regain_request_n_s2 <= 1'b0;
    end else begin
      done_s1 <= done_tgl_reg;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      grant_s1 <= !bus_hold_grant_n;
      grant_s2 <= grant_s1;
      bus_regain_request_n_s1 <= !bus_regain_request_n;
      bus_regain_request_n_s2 <= bus_regain_request_n_s1;
    end
  end

  // write address and data channels, taken in either order
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= ebs_pkg::ZERO32;
      w_strb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= ebs_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_reg <= awaddr;
        aw_have <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
        w_have <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b1;
        if (aw_addr_reg[7:0] == ebs_pkg::CFG_OFS ||
            aw_addr_reg[7:0] == ebs_pkg::ADDR_OFS ||
            aw_addr_reg[7:0] == ebs_pkg::WDATA_OFS ||
            aw_addr_reg[7:0] == ebs_pkg::CMD_OFS) begin
          bresp <= ebs_pkg::RESP_OKAY;
        end else begin
          bresp <= ebs_pkg::RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // register file; setup is frozen while a cycle is under way
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= ebs_pkg::CFG_RST;
      addr_reg <= '0;
      wdata_reg <= '0;
      wr_reg <= 1'b0;
      bhe_reg <= 1'b0;
      busy_reg <= 1'b0;
      req_tgl_reg <= 1'b0;
      rd_reg <= ebs_pkg::ZERO32;
    end else begin
      if (done_evt) begin
        busy_reg <= 1'b0;
        rd_reg <= {16'h0000, link_rd_reg};
      end
      if (do_write && !busy_reg) begin
        if (aw_addr_reg[7:0] == ebs_pkg::CFG_OFS) begin
          cfg_reg <= ebs_merge(cfg_reg, w_data_reg, w_strb_reg) &
                     {16'h0000, 16'hFFFF};
        end else if (aw_addr_reg[7:0] == ebs_pkg::ADDR_OFS) begin
          addr_reg <= 24'(ebs_merge({8'h00, addr_reg}, w_data_reg,
                                    w_strb_reg));
        end else if (aw_addr_reg[7:0] == ebs_pkg::WDATA_OFS) begin
          wdata_reg <= 16'(ebs_merge({16'h0000, wdata_reg}, w_data_reg,
                                     w_strb_reg));
        end else if (aw_addr_reg[7:0] == ebs_pkg::CMD_OFS) begin
          if (w_strb_reg[0] && w_data_reg[ebs_pkg::C_GO]) begin
            wr_reg <= w_data_reg[ebs_pkg::C_WR];
            bhe_reg <= w_data_reg[ebs_pkg::C_BHE];
            busy_reg <= 1'b1;
            req_tgl_reg <= !req_tgl_reg;
          end
        end
      end
    end
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= ebs_pkg::ZERO32;
      rresp <= ebs_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= ebs_pkg::RESP_OKAY;
        if (araddr[7:0] == ebs_pkg::CFG_OFS) begin
          rdata <= cfg_reg;
        end else if (araddr[7:0] == ebs_pkg::ADDR_OFS) begin
          rdata <= {8'h00, addr_reg};
        end else if (araddr[7:0] == ebs_pkg::WDATA_OFS) begin
          rdata <= {16'h0000, wdata_reg};
        end else if (araddr[7:0] == ebs_pkg::CMD_OFS) begin
          rdata <= {29'h0000_0000, bhe_reg, wr_reg, 1'b0};
        end else if (araddr[7:0] == ebs_pkg::STAT_OFS) begin
          rdata <= {29'h0000_0000, bus_regain_request_n_s2, grant_s2, busy_reg};
        end else if (araddr[7:0] == ebs_pkg::RDATA_OFS) begin
          rdata <= rd_reg;
        end else begin
          rdata <= ebs_pkg::ZERO32;
          rresp <= ebs_pkg::RESP_SLVERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ---------------- link clock domain ----------------
  ebs_pkg::ebs_state_t st_reg, st_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [ebs_pkg::CFG_W-1:0] c_reg;
  logic lwr_reg;
  logic [7:0] win_reg;
  logic req_s1, req_s2, req_s3;
  logic hold_s1, hold_s2;
  logic rdy_s1, rdy_s2;
  logic pend_reg;
  logic hold_act, rdy_act, in_acc, nx_acc, wchg;

  assign hold_act = ebs_active(hold_s2, 1'b0);
  assign rdy_act = ebs_active(c_reg[ebs_pkg::F_RASY] ? rdy_s2 : ready_in,
                              c_reg[ebs_pkg::F_RPOL]);
  assign in_acc = st_reg == ebs_pkg::ST_ACC || st_reg == ebs_pkg::ST_RDYW;
  assign nx_acc = st_next == ebs_pkg::ST_ACC ||
                  st_next == ebs_pkg::ST_RDYW;
  assign wchg = addr_reg[23:16] != win_reg;

  always_ff @(posedge link_clock or negedge rstn) begin
    if (!rstn) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      hold_s1 <= 1'b1;
      hold_s2 <= 1'b1;
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end else begin
      req_s1 <= req_tgl_reg;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      hold_s1 <= hold_n;
      hold_s2 <= hold_s1;
      rdy_s1 <= ready_in;
      rdy_s2 <= rdy_s1;
    end
  end

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      ebs_pkg::ST_IDLE: begin
        if (hold_act) begin
          st_next = ebs_pkg::ST_REL;
        end else if (pend_reg) begin
          st_next = ebs_pkg::ST_AS;
          cnt_next = ebs_len(ebs_pkg::ST_AS,
                             cfg_reg[ebs_pkg::CFG_W-1:0], wchg);
        end
      end
      ebs_pkg::ST_AS, ebs_pkg::ST_CMD, ebs_pkg::ST_WSET,
      ebs_pkg::ST_HOLDP: begin
        if (cnt_reg > ebs_pkg::CNT_ONE) begin
          cnt_next = cnt_reg - ebs_pkg::CNT_ONE;
        end else begin
          st_next = ebs_after(st_reg, c_reg);
          cnt_next = ebs_len(st_next, c_reg, 1'b0);
        end
      end
      ebs_pkg::ST_ACC: begin
        if (cnt_reg > ebs_pkg::CNT_ONE) begin
          cnt_next = cnt_reg - ebs_pkg::CNT_ONE;
        end else if (c_reg[ebs_pkg::F_REN]) begin
          st_next = ebs_pkg::ST_RDYW;
        end else begin
          st_next = ebs_after(st_reg, c_reg);
          cnt_next = ebs_len(st_next, c_reg, 1'b0);
        end
      end
      ebs_pkg::ST_RDYW: begin
        if (rdy_act) begin
          st_next = ebs_after(st_reg, c_reg);
          cnt_next = ebs_len(st_next, c_reg, 1'b0);
        end
      end
      ebs_pkg::ST_REL: st_next = ebs_pkg::ST_HELD;
      ebs_pkg::ST_HELD: begin
        if (!hold_act) begin
          st_next = ebs_pkg::ST_REG;
        end
      end
      ebs_pkg::ST_REG: st_next = ebs_pkg::ST_IDLE;
      default: st_next = ebs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge link_clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ebs_pkg::ST_IDLE;
      cnt_reg <= ebs_pkg::CNT_ZERO;
      pend_reg <= 1'b0;
      c_reg <= '0;
      lwr_reg <= 1'b0;
      win_reg <= 8'h00;
      link_rd_reg <= 16'h0000;
      done_tgl_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      if (req_s2 ^ req_s3) begin
        pend_reg <= 1'b1;
      end else if (st_reg == ebs_pkg::ST_IDLE &&
                   st_next == ebs_pkg::ST_AS) begin
        pend_reg <= 1'b0;
      end
      if (st_next == ebs_pkg::ST_AS && st_reg == ebs_pkg::ST_IDLE) begin
        c_reg <= cfg_reg[ebs_pkg::CFG_W-1:0];
        lwr_reg <= wr_reg;
        win_reg <= addr_reg[23:16];
      end
      if (in_acc && !nx_acc && !lwr_reg) begin
        link_rd_reg <= read_data_in;
      end
      if (st_reg != ebs_pkg::ST_IDLE && st_reg != ebs_pkg::ST_REG &&
          st_reg != ebs_pkg::ST_HELD && st_reg != ebs_pkg::ST_REL &&
          st_next == ebs_pkg::ST_IDLE) begin
        done_tgl_reg <= !done_tgl_reg;
      end
    end
  end

  // pin drivers follow the next state so each phase lines up with its edge
  always_ff @(posedge link_clock or negedge rstn) begin
    if (!rstn) begin
      address_out <= 24'h00_0000;
      address_oe <= 1'b1;
      write_data_out <= 16'h0000;
      write_data_oe <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      address_latch_enable <= 1'b0;
      byte_high_enable_n <= 1'b1;
      control_oe <= 1'b1;
      bus_hold_grant_n <= 1'b1;
      bus_regain_request_n <= 1'b1;
    end else begin
      if (st_reg == ebs_pkg::ST_IDLE && st_next == ebs_pkg::ST_AS) begin
        address_out <= addr_reg;
        write_data_out <= wdata_reg;
        byte_high_enable_n <= !bhe_reg;
      end
      address_latch_enable <= st_next == ebs_pkg::ST_AS;
      read_strobe_n <= !(nx_acc && !lwr_reg);
      write_strobe_n <= !(nx_acc && lwr_reg);
      write_data_oe <= lwr_reg && (nx_acc ||
          st_next == ebs_pkg::ST_WSET || st_next == ebs_pkg::ST_HOLDP);
      control_oe <= st_next != ebs_pkg::ST_HELD;
      address_oe <= st_next != ebs_pkg::ST_HELD;
      bus_hold_grant_n <= st_next != ebs_pkg::ST_HELD;
      bus_regain_request_n <= !(st_next == ebs_pkg::ST_HELD &&
                                pend_reg);
    end
  end
endmodule

// ---- testbench/ebs_assertions.sv ----
// checks on the bus pins of the cycle sequencer
`timescale 1ns/1ps
module ebs_chk (
  input wire logic link_clock,
  input wire logic rstn,
  input wire logic hold_n,
  input wire logic address_latch_enable,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic control_oe,
  input wire logic address_oe,
  input wire logic bus_hold_grant_n,
  input wire logic bus_regain_request_n
);
  default clocking cb @(posedge link_clock);
  endclocking
  default disable iff (!rstn);
  property p_ale_len;
    $rose(address_latch_enable) |-> ##[1:5] !address_latch_enable;
  endproperty
  a_ale_len: assert property (p_ale_len)
    else $error("address setup too long");
  property p_one_cmd;
    !read_strobe_n |-> write_strobe_n;
  endproperty
  a_one_cmd: assert property (p_one_cmd)
    else $error("both strobes low");
  property p_order;
    !(read_strobe_n && write_strobe_n) |-> !address_latch_enable;
  endproperty
  a_order: assert property (p_order)
    else $error("strobe overlaps address setup");
  property p_grant_quiet;
    !bus_hold_grant_n |->
      read_strobe_n && write_strobe_n && !address_latch_enable;
  endproperty
  a_grant_quiet: assert property (p_grant_quiet)
    else $error("bus cycle while granted");
  property p_float;
    !bus_hold_grant_n |-> !control_oe && !address_oe;
  endproperty
  a_float: assert property (p_float)
    else $error("outputs driven while granted");
  property p_grant_cause;
    $fell(bus_hold_grant_n) |-> !$past(hold_n, 2) && $past(control_oe);
  endproperty
  a_grant_cause: assert property (p_grant_cause)
    else $error("grant without hold or release");
  property p_regain;
    $rose(bus_hold_grant_n) |->
      $past(hold_n, 2) && control_oe && !address_latch_enable;
  endproperty
  a_regain: assert property (p_regain)
    else $error("bad regain");
  property p_bus_regain_request_n_held;
    !bus_regain_request_n |-> !bus_hold_grant_n;
  endproperty
  a_bus_regain_request_n_held: assert property (p_bus_regain_request_n_held)
    else $error("regain request while not granted");
endmodule

bind ebs_top ebs_chk i_ebs_chk (
  .link_clock(link_clock), .rstn(rstn), .hold_n(hold_n),
  .address_latch_enable(address_latch_enable),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .control_oe(control_oe), .address_oe(address_oe),
  .bus_hold_grant_n(bus_hold_grant_n),
  .bus_regain_request_n(bus_regain_request_n)
);

// ---- testbench/ebs_ext_model.sv ----
// external memory and second bus master at the bus pins
`timescale 1ns/1ps
module ebs_ext_model (
  input wire logic link_clock,
  input wire logic rstn,
  input wire logic [23:0] address_out,
  input wire logic [15:0] write_data_out,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic byte_high_enable_n,
  input wire logic rdy_high,
  input wire logic [3:0] rdy_wait,
  input wire logic hold_req,
  output logic ready_in,
  output logic [15:0] read_data_in,
  output logic hold_n,
  output logic [23:0] wr_addr,
  output logic [15:0] wr_data,
  output logic wr_bhe_n
);
  logic [3:0] cnt_reg;
  logic [15:0] junk_reg;
  wire logic stb = !read_strobe_n || !write_strobe_n;
  // data only while read strobe is low, junk otherwise
  assign read_data_in = read_strobe_n ? junk_reg
    : address_out[15:0] ^ 16'h5A5A;
  always_ff @(posedge link_clock or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
      ready_in <= 1'b0;
      junk_reg <= 16'h0000;
      hold_n <= 1'b1;
    end else begin
      junk_reg <= ~junk_reg;
      hold_n <= !hold_req;
      cnt_reg <= stb ? cnt_reg + 4'h1 : 4'h0;
      // ready kept until the strobe rises
      if (!stb) begin
        ready_in <= !rdy_high;
      end else if (cnt_reg + 4'h1 >= rdy_wait) begin
        ready_in <= rdy_high;
      end
    end
  end
  always_ff @(posedge link_clock) begin
    if (!write_strobe_n) begin
      wr_addr <= address_out;
      wr_data <= write_data_out;
      wr_bhe_n <= byte_high_enable_n;
    end
  end
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the external bus cycle sequencer
`timescale 1ns/1ps
module testbench;
  logic clock, rstn, link_clock, ready_in, hold_n, rdy_high, hold_req;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, r;
  logic [3:0] wstrb, rdy_wait;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] read_data_in, write_data_out, wr_data;
  logic [23:0] address_out, wr_addr;
  logic address_oe, write_data_oe, read_strobe_n, write_strobe_n;
  logic address_latch_enable, byte_high_enable_n, control_oe;
  logic bus_hold_grant_n, bus_regain_request_n, wr_bhe_n;
  logic seen_ale, seen_stb;
  int fails, n_tests, ale_cnt, gap_cnt, stb_cnt, hld_cnt, len;
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #1.3;
    forever #7.5 link_clock = ~link_clock;
  end
  ebs_top i_ebs_top (.clock(clock), .rstn(rstn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link_clock(link_clock), .ready_in(ready_in),
    .hold_n(hold_n), .read_data_in(read_data_in),
    .address_out(address_out), .address_oe(address_oe),
    .write_data_out(write_data_out), .write_data_oe(write_data_oe),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .address_latch_enable(address_latch_enable),
    .byte_high_enable_n(byte_high_enable_n), .control_oe(control_oe),
    .bus_hold_grant_n(bus_hold_grant_n),
    .bus_regain_request_n(bus_regain_request_n));
  ebs_ext_model i_ebs_ext_model (.link_clock(link_clock), .rstn(rstn),
    .address_out(address_out), .write_data_out(write_data_out),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .byte_high_enable_n(byte_high_enable_n), .rdy_high(rdy_high),
    .rdy_wait(rdy_wait), .hold_req(hold_req), .ready_in(ready_in),
    .read_data_in(read_data_in), .hold_n(hold_n), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_bhe_n(wr_bhe_n));
  // phase lengths in link periods
  always @(posedge link_clock) begin
    if (address_latch_enable) begin
      ale_cnt++;
      seen_ale = 1'b1;
    end else if (!read_strobe_n || !write_strobe_n) begin
      stb_cnt++;
      seen_stb = 1'b1;
    end else if (seen_stb && write_data_oe) begin
      hld_cnt++;
    end else if (seen_ale && !seen_stb) begin
      gap_cnt++;
    end
  end
  task automatic clr();
    ale_cnt = 0;
    gap_cnt = 0;
    stb_cnt = 0;
    hld_cnt = 0;
    seen_ale = 1'b0;
    seen_stb = 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] s);
    logic done;
    done = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        s = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] s);
    logic done;
    done = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        s = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // poll status until the given bit reads v
  task automatic poll(input int b, input logic v);
    r = {32{!v}};
    for (int i = 0; i < 200 && r[b] !== v; i++) begin
      rd(ebs_pkg::STAT_OFS, r, rsp);
    end
    chk("poll", {31'h0, v}, {31'h0, r[b]});
  endtask
  task automatic cyc(input logic [31:0] cfg, adr, cmd,
      input int ea, eg, es, eh);
    logic [31:0] d;
    d = adr ^ 32'h0000_C3C3;
    wr(ebs_pkg::CFG_OFS, cfg, rsp);
    wr(ebs_pkg::ADDR_OFS, adr, rsp);
    wr(ebs_pkg::WDATA_OFS, d, rsp);
    clr();
    wr(ebs_pkg::CMD_OFS, cmd, rsp);
    poll(ebs_pkg::S_BUSY, 1'b0);
    chk("setup", ea, ale_cnt);
    chk("cmd delay", eg, gap_cnt);
    if (es >= 0) chk("access", es, stb_cnt);
    chk("hold", eh, hld_cnt);
    if (!cmd[ebs_pkg::C_WR]) begin
      rd(ebs_pkg::RDATA_OFS, r, rsp);
      chk("rdata", {16'h0000, adr[15:0] ^ 16'h5A5A}, r);
    end else begin
      chk("wdata", {16'h0000, d[15:0]}, {16'h0000, wr_data});
      chk("waddr", {8'h00, adr[23:0]}, {8'h00, wr_addr});
      chk("bhe", {31'h0, !cmd[ebs_pkg::C_BHE]}, {31'h0, wr_bhe_n});
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    rdy_high = 1'b1;
    rdy_wait = 4'h3;
    hold_req = 1'b0;
    fails = 0;
    n_tests = 0;
    clr();
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    rd(ebs_pkg::CFG_OFS, r, rsp);
    chk("cfg reset", ebs_pkg::CFG_RST, r);
    rd(8'h3C, r, rsp);
    chk("bad read", {30'h0, ebs_pkg::RESP_SLVERR}, {30'h0, rsp});
    wr(8'h3C, 32'h0000_FFFF, rsp);
    chk("bad write", {30'h0, ebs_pkg::RESP_SLVERR}, {30'h0, rsp});
    wstrb <= 4'h2;
    wr(ebs_pkg::CFG_OFS, 32'h0000_FFFF, rsp);
    wstrb <= 4'hF;
    rd(ebs_pkg::CFG_OFS, r, rsp);
    chk("byte strobe", 32'h0000_FF00, r);
    cyc(32'h0000_0000, 32'h0000_1234, 1, 1, 0, 1, 0);
    cyc(32'h0000_1FF9, 32'h0000_0042, 7, 2, 4, 32, 3);
    cyc(32'h0000_0007, 32'h0012_0010, 1, 5, 0, 1, 0);
    cyc(32'h0000_0002, 32'h0012_0020, 1, 1, 0, 1, 0);
    cyc(32'h0000_0800, 32'h0012_0030, 3, 1, 0, 1, 1);
    cyc(32'h0000_6000, 32'h0012_0040, 1, 1, 0, -1, 0);
    len = stb_cnt;
    chk("waitstate", {28'h000_0000, rdy_wait} + 32'h0000_0001, len);
    rdy_high <= 1'b0;
    cyc(32'h0000_2000, 32'h0012_0050, 1, 1, 0, len, 0);
    rdy_high <= 1'b1;
    cyc(32'h0000_E000, 32'h0012_0060, 1, 1, 0, -1, 0);
    chk("async", 1, stb_cnt > len);
    // hold asked while a long write is running
    wr(ebs_pkg::CFG_OFS, 32'h0000_1FF9, rsp);
    clr();
    wr(ebs_pkg::CMD_OFS, 32'h0000_0003, rsp);
    for (int i = 0; i < 200 && stb_cnt == 0; i++) @(posedge clock);
    hold_req <= 1'b1;
    poll(ebs_pkg::S_GRANT, 1'b1);
    chk("finished", 32, stb_cnt);
    chk("no regain", 1, bus_regain_request_n);
    clr();
    wr(ebs_pkg::CMD_OFS, 32'h0000_0001, rsp);
    poll(ebs_pkg::S_BUS_REGAIN_REQUEST_N, 1'b1);
    chk("status held", 32'h0000_0007, r);
    chk("held idle", 0, ale_cnt);
    wr(ebs_pkg::CFG_OFS, 32'h0000_0000, rsp);
    rd(ebs_pkg::CFG_OFS, r, rsp);
    chk("cfg frozen", 32'h0000_1FF9, r);
    hold_req <= 1'b0;
    poll(ebs_pkg::S_BUSY, 1'b0);
    chk("status free", 32'h0000_0000, r);
    chk("regained", 2, ale_cnt);
    end_of_test();
  end
endmodule
